/* include/codec_pack_pkg.sv */
/*
 Shared definitions for the codec sample packer: register offsets,
 control layout, sample formats and the per-format packing figures.
 Assumes a 32-bit AHB-Lite register bus and a single 100 MHz clock.
*/
package codec_pack_pkg;
    localparam int CNT_W = 16;
    localparam int PKT_W = 32;
    localparam int SMP_W = 16;
    localparam int CTRL_W = 7;
    localparam int ADDR_LSB_W = 8;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE = 8'h04;
    localparam logic [7:0] OFS_CURR = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_NARROW = 8'h18;

    localparam int UF_BIT = 0;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [1:0] UNIT_LAST_BYTE = 2'h3;
    localparam logic [1:0] UNIT_LAST_WORD = 2'h1;
    localparam logic [PKT_W-1:0] BYTE_MASK = 32'h0000_00FF;
    localparam logic [PKT_W-1:0] WORD_MASK = 32'h0000_FFFF;

    typedef enum logic [2:0] {
        FMT_BE16, FMT_LE16, FMT_U8, FMT_MULAW, FMT_ALAW, FMT_ADPCM4
    } fmt_t;

    typedef struct packed {
        logic enable;
        logic byte_wide_interface_select;
        logic byte_swap_select;
        logic stereo;
        fmt_t fmt;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic [SMP_W-1:0] right;
        logic [SMP_W-1:0] left;
    } sample_t;

    localparam logic [4:0] BITS_16 = 5'h10;
    localparam logic [4:0] BITS_8 = 5'h08;
    localparam logic [4:0] BITS_4 = 5'h04;
    localparam logic [3:0] SLOTS_16 = 4'h2;
    localparam logic [3:0] SLOTS_8 = 4'h4;
    localparam logic [3:0] SLOTS_4 = 4'h8;

    // Slot width per format; unused codes act as 8-bit
    function automatic logic [4:0] slot_bits(input fmt_t f);
        if (f == FMT_BE16 || f == FMT_LE16) return BITS_16;
        else if (f == FMT_ADPCM4) return BITS_4;
        return BITS_8;
    endfunction

    function automatic logic [3:0] slots_per_packet(input fmt_t f);
        logic [4:0] b;
        b = slot_bits(f);
        if (b == BITS_16) return SLOTS_16;
        else if (b == BITS_4) return SLOTS_4;
        return SLOTS_8;
    endfunction

    function automatic logic [3:0] samples_per_packet(input fmt_t f, input logic stereo);
        return stereo ? (slots_per_packet(f) >> 1) : slots_per_packet(f);
    endfunction
endpackage

/* verilog/sample_packer.sv */
/*
 Packs codec samples into 32-bit packets, slot by slot from bit 0 upward.
 Assumes configuration is changed only while clear is high.
*/
`timescale 1ns/10ps
module sample_packer (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input codec_pack_pkg::ctrl_t cfg,
    input codec_pack_pkg::sample_t smp,
    input wire logic smp_valid,
    output logic smp_ready,
    output logic [codec_pack_pkg::PKT_W-1:0] pkt,
    output logic pkt_valid,
    input wire logic pkt_ready
);
    import codec_pack_pkg::*;

    logic [PKT_W-1:0] acc_q, acc_d;
    logic [3:0] slot_q, slot_d;
    logic full_q, full_d;
    logic rdy_q, rdy_d;
    logic [4:0] wb;
    logic [5:0] sh;
    logic [PKT_W-1:0] piece;
    logic take;

    function automatic logic [SMP_W-1:0] encode(input logic [SMP_W-1:0] d, input ctrl_t c);
        logic [4:0] b;
        b = slot_bits(c.fmt);
        if (b == BITS_16) begin
            if ((c.fmt == FMT_BE16) ^ c.byte_swap_select) return {d[7:0], d[15:8]};
            return d;
        end
        else if (b == BITS_8) return {8'h00, d[7:0]};
        return {12'h000, d[3:0]};
    endfunction

    always_comb begin
        take = smp_valid && rdy_q;
        wb = slot_bits(cfg.fmt);
        sh = 6'(slot_q * wb);
        piece = {16'h0000, encode(smp.left, cfg)};
        // Right sits one slot above its left
        if (cfg.stereo) piece = piece | (PKT_W'(encode(smp.right, cfg)) << wb);
        acc_d = acc_q;
        slot_d = slot_q;
        full_d = full_q;
        if (clear || (full_q && pkt_ready)) begin
            acc_d = '0;
            slot_d = '0;
            full_d = 1'b0;
        end
        else if (take) begin
            acc_d = acc_q | (piece << sh);
            slot_d = slot_q + (cfg.stereo ? 4'h2 : 4'h1);
            full_d = (slot_d == slots_per_packet(cfg.fmt));
        end
        rdy_d = !full_d && !clear;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_q <= '0;
            slot_q <= '0;
            full_q <= 1'b0;
            rdy_q <= 1'b0;
        end
        else begin
            acc_q <= acc_d;
            slot_q <= slot_d;
            full_q <= full_d;
            rdy_q <= rdy_d;
        end
    end

    assign smp_ready = rdy_q;
    assign pkt = acc_q;
    assign pkt_valid = full_q;

    property p_packet_full;
        @(posedge clk) disable iff (reset)
        pkt_valid |-> slot_q == slots_per_packet(cfg.fmt);
    endproperty
    a_packet_full: assert property (p_packet_full) else $error("packet offered before full");

    property p_be16_order;
        @(posedge clk) disable iff (reset)
        take && !clear && !full_q && cfg.fmt == FMT_BE16 && !cfg.byte_swap_select && slot_q == 4'h0
        |=> acc_q[15:0] == {$past(smp.left[7:0]), $past(smp.left[15:8])};
    endproperty
    a_be16_order: assert property (p_be16_order) else $error("big-endian byte order wrong");

    property p_adpcm_stereo;
        @(posedge clk) disable iff (reset)
        take && !clear && !full_q && cfg.fmt == FMT_ADPCM4 && cfg.stereo && slot_q == 4'h0
        |=> acc_q[7:0] == {$past(smp.right[3:0]), $past(smp.left[3:0])};
    endproperty
    a_adpcm_stereo: assert property (p_adpcm_stereo) else $error("stereo nibble order wrong");
endmodule

/* verilog/codec_sample_packer_counter.sv */
/*
 Codec capture packer with sample counter, AHB-Lite register slave
 and underflow interrupt.
 Assumes a single-word AHB-Lite master and synchronous codec inputs.
*/
// Behaviour
// - Six formats: BE16, LE16, U8, mu-law, A-law, ADPCM4
// - Every transfer moves one full 32-bit packet
// - Counters hold samples, not packets
// - Each packet subtracts its sample count
// - Underflow after trunc(count/per packet)+1 transfers
// - Big-endian upper byte first, little-endian lower
// - Mono uses left channel only
// - 8-bit mono: four samples, sample 0 lowest
// - 8-bit stereo: L0, R0, L1, upward
// - 16-bit LE stereo: left word 0, right word 1
// - 16-bit BE: lower byte in high half
// - ADPCM mono: eight nibbles, sample 0 lowest
// - ADPCM stereo: left nibble below right, alternating
// - Underflow raises flag and reloads current count
// - Current loads only on base write or underflow
// - Byte-wide select sends four bytes, byte 0 first
`timescale 1ns/10ps
module codec_sample_packer_counter (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input codec_pack_pkg::sample_t smp,
    input wire logic smp_valid,
    output logic smp_ready,
    output logic irq
);
    import codec_pack_pkg::*;

    typedef enum logic [2:0] {
        SEL_CTRL, SEL_BASE, SEL_CURR, SEL_STAT, SEL_MASK, SEL_DATA, SEL_NARROW, SEL_NONE
    } sel_t;

    function automatic sel_t decode(input logic [ADDR_LSB_W-1:0] a);
        if (a == OFS_CTRL) return SEL_CTRL;
        else if (a == OFS_BASE) return SEL_BASE;
        else if (a == OFS_CURR) return SEL_CURR;
        else if (a == OFS_STAT) return SEL_STAT;
        else if (a == OFS_MASK) return SEL_MASK;
        else if (a == OFS_DATA) return SEL_DATA;
        else if (a == OFS_NARROW) return SEL_NARROW;
        return SEL_NONE;
    endfunction

    ctrl_t ctrl_q, ctrl_d;
    logic [CNT_W-1:0] base_q, base_d;
    logic [CNT_W-1:0] cur_q, cur_d;
    logic stat_q, stat_d;
    logic mask_q, mask_d;
    logic irq_q, irq_d;
    logic [1:0] nar_q, nar_d;
    logic wr_q, wr_d;
    sel_t wsel_q, wsel_d;
    logic [PKT_W-1:0] rdata_q, rdata_d;
    logic ready_q;
    logic resp_q;

    logic ap;
    logic rd;
    sel_t rd_sel;
    logic xfer;
    logic base_wr;
    logic set_uf;
    logic last;
    logic [CNT_W-1:0] spp;
    logic [PKT_W-1:0] pkt;
    logic pkt_valid;
    logic clear;
    logic stat_clr;

    assign clear = !ctrl_q.enable;

    sample_packer u_packer (
        .clk(clk),
        .reset(reset),
        .clear(clear),
        .cfg(ctrl_q),
        .smp(smp),
        .smp_valid(smp_valid),
        .smp_ready(smp_ready),
        .pkt(pkt),
        .pkt_valid(pkt_valid),
        .pkt_ready(xfer)
    );

    // Bus decode and register file
    always_comb begin
        ap = hsel && hready && htrans[1];
        rd = ap && !hwrite;
        rd_sel = decode(haddr[ADDR_LSB_W-1:0]);
        wr_d = ap && hwrite;
        wsel_d = ap ? rd_sel : SEL_NONE;
        ctrl_d = ctrl_q;
        base_d = base_q;
        mask_d = mask_q;
        stat_clr = 1'b0;
        nar_d = clear ? 2'h0 : nar_q;
        rdata_d = '0;
        xfer = 1'b0;
        base_wr = 1'b0;
        last = 1'b0;
        if (rd) begin
            if (rd_sel == SEL_CTRL) rdata_d = PKT_W'(ctrl_q);
            else if (rd_sel == SEL_BASE) rdata_d = PKT_W'(base_q);
            else if (rd_sel == SEL_CURR) rdata_d = PKT_W'(cur_q);
            else if (rd_sel == SEL_STAT) rdata_d = PKT_W'(stat_q);
            else if (rd_sel == SEL_MASK) rdata_d = PKT_W'(mask_q);
            else if (rd_sel == SEL_DATA) begin
                if (pkt_valid) begin
                    rdata_d = pkt;
                    xfer = 1'b1;
                end
            end
            else if (rd_sel == SEL_NARROW) begin
                if (pkt_valid) begin
                    // Narrow interface walks the packet from the bottom up
                    if (ctrl_q.byte_wide_interface_select) begin
                        rdata_d = (pkt >> {nar_q, 3'h0}) & BYTE_MASK;
                        last = (nar_q == UNIT_LAST_BYTE);
                    end
                    else begin
                        rdata_d = (pkt >> {nar_q, 4'h0}) & WORD_MASK;
                        last = (nar_q == UNIT_LAST_WORD);
                    end
                    nar_d = last ? 2'h0 : nar_q + 2'h1;
                    xfer = last;
                end
            end
        end
        if (wr_q) begin
            if (wsel_q == SEL_CTRL) ctrl_d = ctrl_t'(hwdata[CTRL_W-1:0]);
            else if (wsel_q == SEL_BASE) begin
                base_d = hwdata[CNT_W-1:0];
                base_wr = 1'b1;
            end
            else if (wsel_q == SEL_STAT) begin
                stat_clr = hwdata[UF_BIT];
            end
            else if (wsel_q == SEL_MASK) mask_d = hwdata[UF_BIT];
        end
    end

    // Sample counter
    always_comb begin
        spp = CNT_W'(samples_per_packet(ctrl_q.fmt, ctrl_q.stereo));
        cur_d = cur_q;
        set_uf = 1'b0;
        if (base_wr) cur_d = base_d;
        else if (xfer) begin
            if (cur_q < spp) begin
                cur_d = base_q;
                set_uf = 1'b1;
            end
            else cur_d = cur_q - spp;
        end
        // Hardware set beats a same-cycle software clear
        stat_d = stat_q;
        if (stat_clr) stat_d = 1'b0;
        if (set_uf) stat_d = 1'b1;
        irq_d = stat_d && mask_d;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            base_q <= '0;
            cur_q <= '0;
            stat_q <= 1'b0;
            mask_q <= 1'b0;
            irq_q <= 1'b0;
            nar_q <= 2'h0;
            wr_q <= 1'b0;
            wsel_q <= SEL_NONE;
            rdata_q <= '0;
            ready_q <= 1'b1;
            resp_q <= HRESP_OKAY;
        end
        else begin
            ctrl_q <= ctrl_d;
            base_q <= base_d;
            cur_q <= cur_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            nar_q <= nar_d;
            wr_q <= wr_d;
            wsel_q <= wsel_d;
            rdata_q <= rdata_d;
            ready_q <= 1'b1;
            resp_q <= HRESP_OKAY;
        end
    end

    assign hreadyout = ready_q;
    assign hrdata = rdata_q;
    assign hresp = resp_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_reset_state;
        $past(reset) |-> cur_q == '0 && !stat_q && !irq;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state not clear after reset");

    property p_underflow;
        xfer && !base_wr && cur_q < spp |=> stat_q ##1 (irq == mask_q);
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow flag not raised");

    property p_reload;
        xfer && !base_wr && cur_q < spp |=> cur_q == $past(base_q);
    endproperty
    a_reload: assert property (p_reload) else $error("count not reloaded on underflow");

    property p_decrement;
        xfer && !base_wr && cur_q >= spp |=> cur_q == $past(cur_q) - $past(spp) && !$rose(stat_q);
    endproperty
    a_decrement: assert property (p_decrement) else $error("count not reduced by packet samples");

    property p_load_only;
        !xfer && !base_wr |=> $stable(cur_q);
    endproperty
    a_load_only: assert property (p_load_only) else $error("current count changed without cause");

    property p_narrow_byte0;
        rd && rd_sel == SEL_NARROW && pkt_valid && nar_q == 2'h0 && ctrl_q.byte_wide_interface_select
        |=> hrdata == {24'h00_0000, $past(pkt[7:0])} && nar_q == 2'h1;
    endproperty
    a_narrow_byte0: assert property (p_narrow_byte0) else $error("byte 0 not sent first");

    property p_narrow_last_byte;
        rd && rd_sel == SEL_NARROW && pkt_valid && nar_q == UNIT_LAST_BYTE && ctrl_q.byte_wide_interface_select
        |=> hrdata == {24'h00_0000, $past(pkt[31:24])} && !pkt_valid;
    endproperty
    a_narrow_last_byte: assert property (p_narrow_last_byte) else $error("byte 3 not the last unit");

    property p_narrow_word;
        rd && rd_sel == SEL_NARROW && pkt_valid && nar_q == UNIT_LAST_WORD && !ctrl_q.byte_wide_interface_select
        |=> hrdata == {16'h0000, $past(pkt[31:16])} && nar_q == 2'h0 && !pkt_valid;
    endproperty
    a_narrow_word: assert property (p_narrow_word) else $error("word 1 not the last unit");

    property p_data_whole;
        rd && rd_sel == SEL_DATA && pkt_valid |=> hrdata == $past(pkt) && !pkt_valid;
    endproperty
    a_data_whole: assert property (p_data_whole) else $error("packet not handed over whole");

    property p_data_empty;
        rd && rd_sel == SEL_DATA && !pkt_valid |=> hrdata == '0;
    endproperty
    a_data_empty: assert property (p_data_empty) else $error("empty data read not zero");

    property p_read_idle;
        !rd |=> hrdata == '0;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data held past its cycle");

    property p_base_load;
        base_wr |=> cur_q == base_q;
    endproperty
    a_base_load: assert property (p_base_load) else $error("base write did not load count");

    property p_w1c;
        wr_q && wsel_q == SEL_STAT && hwdata[UF_BIT] && !set_uf |=> !stat_q;
    endproperty
    a_w1c: assert property (p_w1c) else $error("status not cleared by write of one");

    property p_stat_rise;
        !set_uf |=> !$rose(stat_q);
    endproperty
    a_stat_rise: assert property (p_stat_rise) else $error("status set without underflow");

    property p_irq_level;
        irq == (stat_q && mask_q);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_clear_flush;
        clear |=> !pkt_valid && !smp_ready;
    endproperty
    a_clear_flush: assert property (p_clear_flush) else $error("partial packet kept while disabled");

    property p_ready_again;
        xfer && pkt_valid && !clear |=> !pkt_valid && smp_ready;
    endproperty
    a_ready_again: assert property (p_ready_again) else $error("input not ready after packet read");

    property p_reset_out;
        $past(reset) |-> hreadyout && hresp == HRESP_OKAY && hrdata == '0 && !smp_ready;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("bus outputs wrong after reset");
endmodule

/* bench/sample_source.sv */
/*
 Codec-side sample source for the capture packer.
 Assumes the bench calls push through the hierarchy, one sample at a time.
*/
`timescale 1ns/10ps
module sample_source (
    clk,
    smp,
    smp_valid,
    smp_ready
);
    import codec_pack_pkg::*;
    input wire logic clk;
    output codec_pack_pkg::sample_t smp;
    output logic smp_valid;
    input wire logic smp_ready;

    initial begin
        smp = '0;
        smp_valid = 1'b0;
    end

    // Optional idle cycles give a slow source
    task automatic push(input sample_t s, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        smp <= s;
        smp_valid <= 1'b1;
        do @(posedge clk); while (smp_ready !== 1'b1);
        smp_valid <= 1'b0;
        // Released data does not keep the last value
        smp <= ~s;
    endtask
endmodule

/* bench/tb_top.sv */
/*
 Self-checking bench for the codec sample packer and counter.
 Assumes a zero-wait AHB-Lite slave and the sample_source partner.
*/
`timescale 1ns/10ps
module tb_top;
    import codec_pack_pkg::*;
    logic clk;
    logic reset;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    sample_t smp;
    logic smp_valid;
    logic smp_ready;
    logic irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;

    codec_sample_packer_counter DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .smp(smp),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .irq(irq));
    sample_source src (.clk(clk), .smp(smp), .smp_valid(smp_valid), .smp_ready(smp_ready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        check(r, exp);
    endtask

    function automatic logic [15:0] lft(input int i);
        return {4'hA, 4'(i), 4'h5, 4'(i)};
    endfunction

    function automatic logic [15:0] rgt(input int i);
        return {4'hC, 4'(i), 4'hE, 4'h8 | 4'(i)};
    endfunction

    // Mono drives junk on the right channel
    function automatic sample_t smp_of(input int i, input logic st);
        return '{right: st ? rgt(i) : ~lft(i), left: lft(i)};
    endfunction

    function automatic int wid(input fmt_t f);
        return (f == FMT_BE16 || f == FMT_LE16) ? 16 : (f == FMT_ADPCM4) ? 4 : 8;
    endfunction

    // Slots fill from bit 0; stereo alternates left then right
    function automatic logic [31:0] expect_pkt(input fmt_t f, input logic st);
        logic [15:0] v;
        logic [31:0] p;
        p = 32'h0000_0000;
        for (int k = 0; k < 32 / wid(f); k++) begin
            v = (st && k[0]) ? rgt(k / 2) : lft(st ? k / 2 : k);
            if (f == FMT_BE16) begin
                v = {v[7:0], v[15:8]};
            end
            p = p | (((32'(v)) & ((32'h0000_0001 << wid(f)) - 1)) << (k * wid(f)));
        end
        return p;
    endfunction

    function automatic logic [31:0] ctrl_word(input fmt_t f, input logic st, input logic bw);
        ctrl_t c;
        c = CTRL_RESET;
        c.enable = 1'b1;
        c.byte_wide_interface_select = bw;
        c.stereo = st;
        c.fmt = f;
        return {25'h000_0000, c};
    endfunction

    task automatic feed(input int n, input logic st);
        for (int i = 0; i < n; i++) src.push(smp_of(i, st), i % 2);
        repeat (2) @(posedge clk);
    endtask

    task automatic reset_test();
        rdc(OFS_CURR, 32'h0000_0000);
        rdc(OFS_STAT, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        check({31'h0, hresp}, 32'h0000_0000);
        check({31'h0, hreadyout}, 32'h0000_0001);
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C, 32'h0000_0000);
        wr(OFS_CURR, 32'h0000_0055);
        rdc(OFS_CURR, 32'h0000_0000);
        $display("done reset");
    endtask

    task automatic pack_test(input fmt_t f, input logic st);
        int n;
        n = 32 / wid(f) / (st ? 2 : 1);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_BASE, 32'h0000_0100);
        wr(OFS_CTRL, ctrl_word(f, st, 1'b0));
        feed(n, st);
        check({31'h0, smp_ready}, 32'h0000_0000);
        rdc(OFS_DATA, expect_pkt(f, st));
        rdc(OFS_CURR, 32'h0000_0100 - n);
        $display("done format %0d stereo %0d", f, st);
    endtask

    task automatic uf_test();
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0000);
        wr(OFS_BASE, 32'h0000_0007);
        wr(OFS_CTRL, ctrl_word(FMT_U8, 1'b0, 1'b0));
        for (int t = 0; t <= 7 / 4; t++) begin
            // Seven samples rounded up to whole packets
            feed(4, 1'b0);
            rdc(OFS_DATA, expect_pkt(FMT_U8, 1'b0));
            rdc(OFS_STAT, {31'h0, t == 7 / 4});
        end
        rdc(OFS_CURR, 32'h0000_0007);
        check({31'h0, irq}, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0000_0001);
        feed(4, 1'b0);
        rdc(OFS_DATA, expect_pkt(FMT_U8, 1'b0));
        wr(OFS_MASK, 32'h0000_0001);
        rdc(OFS_CURR, 32'h0000_0003);
        wr(OFS_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0000_0000);
        rdc(OFS_STAT, 32'h0000_0000);
        wr(OFS_BASE, 32'h0000_0009);
        rdc(OFS_CURR, 32'h0000_0009);
        $display("done underflow");
    endtask

    task automatic narrow_test();
        logic [31:0] p;
        p = expect_pkt(FMT_U8, 1'b0);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, ctrl_word(FMT_U8, 1'b0, 1'b1));
        feed(4, 1'b0);
        for (int k = 0; k < 4; k++) rdc(OFS_NARROW, (p >> (8 * k)) & BYTE_MASK);
        rdc(OFS_DATA, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, ctrl_word(FMT_U8, 1'b0, 1'b0));
        feed(4, 1'b0);
        for (int k = 0; k < 2; k++) rdc(OFS_NARROW, (p >> (16 * k)) & WORD_MASK);
        $display("done narrow");
    endtask

    // Swap turns each 16-bit order into the other
    task automatic swap_test();
        ctrl_t c;
        for (int s = 0; s < 2; s++) begin
            c = CTRL_RESET;
            c.enable = 1'b1;
            c.byte_swap_select = 1'b1;
            c.fmt = s[0] ? FMT_LE16 : FMT_BE16;
            wr(OFS_CTRL, 32'h0000_0000);
            wr(OFS_CTRL, {25'h000_0000, c});
            feed(2, 1'b0);
            rdc(OFS_DATA, expect_pkt(s[0] ? FMT_BE16 : FMT_LE16, 1'b0));
        end
        $display("done swap");
    endtask

    initial begin
        reset = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        reset_test();
        // All six formats, mono and stereo
        for (int f = 0; f < 6; f++) begin
            for (int s = 0; s < 2; s++) pack_test(fmt_t'(f), s[0]);
        end
        swap_test();
        uf_test();
        narrow_test();
        conclude();
    end
endmodule
